/* File: hw/cmb_pkg.sv */
package cmb_pkg;

    // ========================================================
    // Register map (word aligned, chosen offsets)
    // ========================================================
    localparam logic [11:0] OFS_MASK_GATING_CTRL = 12'h000;
    localparam logic [11:0] OFS_MASK_SOURCE_SEL  = 12'h004;
    localparam logic [11:0] OFS_CMP4_CTRL        = 12'h008;
    localparam logic [11:0] OFS_STATUS           = 12'h00c;

    // ========================================================
    // Reset values
    // ========================================================
    localparam logic [15:0] RST_MASK_GATING_CTRL = 16'h0000;
    localparam logic [15:0] RST_MASK_SOURCE_SEL  = 16'h0000;
    localparam logic [15:0] RST_CMP4_CTRL        = 16'h0000;

    // ========================================================
    // Mask gating control field positions
    // ========================================================
    localparam int BIT_BLANK_POLARITY = 15;
    localparam int BIT_OR_C_TRUE      = 13;
    localparam int BIT_OR_C_INV       = 12;
    localparam int BIT_OR_B_TRUE      = 11;
    localparam int BIT_OR_B_INV       = 10;
    localparam int BIT_OR_A_TRUE      = 9;
    localparam int BIT_OR_A_INV       = 8;
    localparam int BIT_AND_OUT_INV    = 7;
    localparam int BIT_AND_OUT_TRUE   = 6;
    localparam int BIT_AND_C_TRUE     = 5;
    localparam int BIT_AND_C_INV      = 4;
    localparam int BIT_AND_B_TRUE     = 3;
    localparam int BIT_AND_B_INV      = 2;
    localparam int BIT_AND_A_TRUE     = 1;
    localparam int BIT_AND_A_INV      = 0;
    localparam logic [15:0] MASK_GATING_WMASK = 16'hbfff;

    // ========================================================
    // Source select and comparator four fields
    // ========================================================
    localparam int SRC_A_LSB     = 0;
    localparam int REF_SEL_BIT   = 4;
    localparam int CHAN_SEL_LSB  = 0;
    localparam logic [15:0] MASK_SOURCE_WMASK = 16'h000f;
    localparam logic [15:0] CMP4_CTRL_WMASK   = 16'h0013;

    // Mask A source codes
    localparam logic [3:0] SRC_PWM1_LOW  = 4'h0;
    localparam logic [3:0] SRC_PWM1_HIGH = 4'h1;
    localparam logic [3:0] SRC_PWM2_LOW  = 4'h2;
    localparam logic [3:0] SRC_PWM2_HIGH = 4'h3;
    localparam logic [3:0] SRC_PWM3_LOW  = 4'h4;
    localparam logic [3:0] SRC_PWM3_HIGH = 4'h5;
    localparam logic [3:0] SRC_TRIG_18   = 4'hc;
    localparam logic [3:0] SRC_TRIG_19   = 4'hd;
    localparam logic [3:0] SRC_FAULT_2   = 4'he;
    localparam logic [3:0] SRC_FAULT_4   = 4'hf;

    // Inverting input channel codes
    localparam logic [1:0] CH_EXT_NEG = 2'h0;
    localparam logic [1:0] CH_AMP1    = 2'h1;
    localparam logic [1:0] CH_AMP2    = 2'h2;
    localparam logic [1:0] CH_AMP3    = 2'h3;

    // ========================================================
    // Carriers
    // ========================================================
    typedef struct packed {
        logic pwm_gen1_low;
        logic pwm_gen1_high;
        logic pwm_gen2_low;
        logic pwm_gen2_high;
        logic pwm_gen3_low;
        logic pwm_gen3_high;
        logic trig_gen_out_18;
        logic trig_gen_out_19;
        logic fault_input_two;
        logic fault_input_four;
    } cmb_sources_t;

    typedef struct packed {
        logic [1:0] inv_input_channel_sel;
        logic       noninv_ref_select;
    } cmb_route_t;

    typedef enum logic [1:0] {
        ST_ADDR = 2'b00,
        ST_WR   = 2'b01,
        ST_RD   = 2'b10
    } cmb_bus_st_t;

endpackage

/* File: hw/cmb_gate.sv */
`timescale 1ns/1ps
// ============================================================
// Combinational blanking gate network
// ============================================================
module cmb_gate (
    input  wire logic [15:0] gating,      // Mask gating control
    input  wire logic        mask_in_a,   // Mask input A
    input  wire logic        mask_in_b,   // Mask input B
    input  wire logic        mask_in_c,   // Mask input C
    input  wire logic        cmp_raw,     // Raw comparator result
    output logic             and_gate_result, // AND gate output
    output logic             blank_active,    // OR gate output
    output logic             cmp_blanked      // Comparator after blanking
);
    logic or_term;

    // AND gate: disabled terms contribute a one
    always_comb begin
        and_gate_result =
            (mask_in_a | ~gating[cmb_pkg::BIT_AND_A_TRUE]) &
            (~mask_in_a | ~gating[cmb_pkg::BIT_AND_A_INV]) &
            (mask_in_b | ~gating[cmb_pkg::BIT_AND_B_TRUE]) &
            (~mask_in_b | ~gating[cmb_pkg::BIT_AND_B_INV]) &
            (mask_in_c | ~gating[cmb_pkg::BIT_AND_C_TRUE]) &
            (~mask_in_c | ~gating[cmb_pkg::BIT_AND_C_INV]);
        // An empty AND gate would blank forever, so force it off
        if (gating[5:0] == 6'h00) begin
            and_gate_result = 1'b0;
        end
    end

    // OR gate: true and inverted mask inputs plus the AND output
    always_comb begin
        or_term =
            (mask_in_a & gating[cmb_pkg::BIT_OR_A_TRUE]) |
            (mask_in_b & gating[cmb_pkg::BIT_OR_B_TRUE]) |
            (mask_in_c & gating[cmb_pkg::BIT_OR_C_TRUE]) |
            (~mask_in_a & gating[cmb_pkg::BIT_OR_A_INV]) |
            (~mask_in_b & gating[cmb_pkg::BIT_OR_B_INV]) |
            (~mask_in_c & gating[cmb_pkg::BIT_OR_C_INV]) |
            (and_gate_result & gating[cmb_pkg::BIT_AND_OUT_TRUE]) |
            (~and_gate_result & gating[cmb_pkg::BIT_AND_OUT_INV]);
        blank_active = or_term;
    end

    // Blanking forces the suppressed level to its inactive value
    always_comb begin
        if (!blank_active) begin
            cmp_blanked = cmp_raw;
        end else if (gating[cmb_pkg::BIT_BLANK_POLARITY]) begin
            cmp_blanked = 1'b1;
        end else begin
            cmp_blanked = 1'b0;
        end
    end
endmodule

/* File: hw/cmb_top.sv */
`timescale 1ns/1ps
// Operation
// - Polarity bit set blanks low comparator result; clear blanks high result.
// - Per-input enable routes true mask A, B, C into OR gate.
// - Per-input inverted enable routes inverse mask A, B, C into OR gate.
// - Four-bit field picks mask A source from ten codes; the other six read low.
// - Codes f, e select faults four, two; d, c triggers 19, 18.
// - Codes 0 to 5 select PWM1 low/high, PWM2, PWM3 in order.
// - Reference bit picks internal reference, else external positive pin.
// - Channel select routes inverting input to pin or amplifiers 1-3.
module cmb_top (
    input  wire logic                hclk,       // Bus clock, 50 MHz
    input  wire logic                hresetn,    // Async reset, low
    input  wire logic                hsel,       // Slave select
    input  wire logic [31:0]         haddr,      // Byte address
    input  wire logic [1:0]          htrans,     // Transfer type
    input  wire logic                hwrite,     // Write when high
    input  wire logic [2:0]          hsize,      // Transfer size
    input  wire logic [31:0]         hwdata,     // Write data
    input  wire logic                hready,     // Bus ready in
    output logic [31:0]              hrdata,     // Read data
    output logic                     hreadyout,  // Slave ready
    output logic                     hresp,      // Always OKAY
    input  wire cmb_pkg::cmb_sources_t mask_a_src, // Mask A candidates
    input  wire logic                mask_in_b,  // Mask input B
    input  wire logic                mask_in_c,  // Mask input C
    input  wire logic                cmp_raw,    // Raw comparator result
    output cmb_pkg::cmb_route_t      route,      // Analog input steering
    output logic                     cmp_out,    // Blanked comparator
    output logic                     blank_active // Blanking in force
);
    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        cmb_pkg::cmb_bus_st_t  st;
        logic [11:0]           addr;
        logic [15:0]           gating;
        logic [15:0]           src_sel;
        logic [15:0]           cmp4;
        logic [31:0]           rdata;
        logic                  ready;
        cmb_pkg::cmb_route_t   route;
        logic                  cmp_out;
        logic                  blank;
        logic                  resp;
    } cmb_state_t;

    cmb_state_t state_reg;
    cmb_state_t state_next;

    logic       mask_in_a;
    logic       and_gate_result;
    logic       blank_now;
    logic       cmp_now;
    logic [3:0] status_bits;

    // ========================================================
    // Source selection
    // ========================================================
    // Source lookup for the mask A mux; status readback reads the mux output
    function automatic logic pick_source(input logic [3:0] code,
                                         input cmb_pkg::cmb_sources_t s);
        logic v;
        v = 1'b0;
        unique case (code)
            cmb_pkg::SRC_PWM1_LOW:  v = s.pwm_gen1_low;
            cmb_pkg::SRC_PWM1_HIGH: v = s.pwm_gen1_high;
            cmb_pkg::SRC_PWM2_LOW:  v = s.pwm_gen2_low;
            cmb_pkg::SRC_PWM2_HIGH: v = s.pwm_gen2_high;
            cmb_pkg::SRC_PWM3_LOW:  v = s.pwm_gen3_low;
            cmb_pkg::SRC_PWM3_HIGH: v = s.pwm_gen3_high;
            cmb_pkg::SRC_TRIG_18:   v = s.trig_gen_out_18;
            cmb_pkg::SRC_TRIG_19:   v = s.trig_gen_out_19;
            cmb_pkg::SRC_FAULT_2:   v = s.fault_input_two;
            cmb_pkg::SRC_FAULT_4:   v = s.fault_input_four;
            // Reserved codes read low so a bad setting never blanks through the OR gate's true mask A term
            default:                v = 1'b0;
        endcase
        return v;
    endfunction

    // ========================================================
    // Decode helpers
    // ========================================================
    // Word offset of a bus address; byte lanes are not decoded
    function automatic logic [11:0] word_addr(input logic [31:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'b00};
        return w;
    endfunction

    // Analog steering decode from the comparator four control word
    function automatic cmb_pkg::cmb_route_t steer(input logic [15:0] c);
        cmb_pkg::cmb_route_t r;
        r.noninv_ref_select     = c[cmb_pkg::REF_SEL_BIT];
        r.inv_input_channel_sel = c[cmb_pkg::CHAN_SEL_LSB +: 2];
        return r;
    endfunction

    // Mask A source mux
    always_comb begin
        mask_in_a = pick_source(state_reg.src_sel[cmb_pkg::SRC_A_LSB +: 4],
                                mask_a_src);
    end

    // ========================================================
    // Blanking network
    // ========================================================
    cmb_gate u_gate (
        .gating          (state_reg.gating),
        .mask_in_a       (mask_in_a),
        .mask_in_b       (mask_in_b),
        .mask_in_c       (mask_in_c),
        .cmp_raw         (cmp_raw),
        .and_gate_result (and_gate_result),
        .blank_active    (blank_now),
        .cmp_blanked     (cmp_now)
    );

    // ========================================================
    // Status
    // ========================================================
    // Live status, caught into read data at a status address phase
    always_comb begin
        status_bits = {and_gate_result, mask_in_a, blank_now, cmp_now};
    end

    // ========================================================
    // Next state: bus slave and output registers
    // ========================================================
    always_comb begin
        logic [31:0] rd;
        rd         = 32'h0000_0000;
        state_next = state_reg;
        state_next.ready = 1'b1;
        // Zero wait states and no error case, so always OKAY
        state_next.resp  = 1'b0;
        // Data phase: only a write has work left, with field write masks
        unique case (state_reg.st)
            cmb_pkg::ST_WR: begin
                unique case (state_reg.addr)
                    cmb_pkg::OFS_MASK_GATING_CTRL:
                        state_next.gating =
                            hwdata[15:0] & cmb_pkg::MASK_GATING_WMASK;
                    cmb_pkg::OFS_MASK_SOURCE_SEL:
                        state_next.src_sel =
                            hwdata[15:0] & cmb_pkg::MASK_SOURCE_WMASK;
                    cmb_pkg::OFS_CMP4_CTRL:
                        state_next.cmp4 =
                            hwdata[15:0] & cmb_pkg::CMP4_CTRL_WMASK;
                    default: ;
                endcase
            end
            // Read data was latched at its address phase
            cmb_pkg::ST_RD:   ;
            cmb_pkg::ST_ADDR: ;
            // The fourth code is never entered
            default:          ;
        endcase
        state_next.st = cmb_pkg::ST_ADDR;
        // Address phase: read data is prepared one cycle ahead
        if (hsel && hready && htrans[1]) begin
            state_next.addr = word_addr(haddr);
            if (hwrite) begin
                state_next.st = cmb_pkg::ST_WR;
            end else begin
                state_next.st = cmb_pkg::ST_RD;
                unique case (word_addr(haddr))
                    cmb_pkg::OFS_MASK_GATING_CTRL:
                        rd = {16'h0000, state_reg.gating};
                    cmb_pkg::OFS_MASK_SOURCE_SEL:
                        rd = {16'h0000, state_reg.src_sel};
                    cmb_pkg::OFS_CMP4_CTRL:
                        rd = {16'h0000, state_reg.cmp4};
                    cmb_pkg::OFS_STATUS:
                        rd = {28'h0000000, status_bits};
                    default: rd = 32'h0000_0000;
                endcase
            end
            state_next.rdata = rd;
        end
        // Analog steering and blanked comparator, registered
        state_next.route   = steer(state_reg.cmp4);
        state_next.cmp_out = cmp_now;
        state_next.blank   = blank_now;
    end

    // ========================================================
    // State register
    // ========================================================
    // Asynchronous clear; everything else moves on the clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg.st      <= cmb_pkg::ST_ADDR;
            state_reg.addr    <= 12'h000;
            state_reg.gating  <= cmb_pkg::RST_MASK_GATING_CTRL;
            state_reg.src_sel <= cmb_pkg::RST_MASK_SOURCE_SEL;
            state_reg.cmp4    <= cmb_pkg::RST_CMP4_CTRL;
            state_reg.rdata   <= 32'h0000_0000;
            state_reg.ready   <= 1'b1;
            state_reg.route   <= '0;
            state_reg.cmp_out <= 1'b0;
            state_reg.blank   <= 1'b0;
            state_reg.resp    <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    // Outputs straight from flops, no logic after the register
    assign hrdata       = state_reg.rdata;
    assign hreadyout    = state_reg.ready;
    assign hresp        = state_reg.resp;
    assign route        = state_reg.route;
    assign cmp_out      = state_reg.cmp_out;
    assign blank_active = state_reg.blank;
endmodule

/* File: bench/cmb_src_model.sv */
`timescale 1ns/1ps
// ========================================================
// Far side: PWM, trigger and fault source levels
module cmb_src_model (
    input  wire logic                 hclk,    // Clock
    input  wire logic                 hresetn, // Reset, low
    input  wire logic [9:0]           pat,     // Wanted levels
    output cmb_pkg::cmb_sources_t     src      // Source levels
);
    // Registered, as a real generator output is
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            src <= '0;
        else
            src <= pat;
    end
endmodule

/* File: bench/cmb_asserts.sv */
`timescale 1ns/1ps
// ========================================================
// Port checker for the blanking block
module cmb_asserts (
    input wire logic                  hclk,         // Clock
    input wire logic                  hresetn,      // Reset, low
    input wire logic                  hsel,         // Select
    input wire logic [31:0]           haddr,        // Address
    input wire logic [1:0]            htrans,       // Type
    input wire logic                  hwrite,       // Write
    input wire logic [2:0]            hsize,        // Size
    input wire logic [31:0]           hwdata,       // Write data
    input wire logic                  hready,       // Ready in
    input wire logic [31:0]           hrdata,       // Read data
    input wire logic                  hreadyout,    // Ready out
    input wire logic                  hresp,        // Response
    input wire cmb_pkg::cmb_sources_t mask_a_src,   // Sources
    input wire logic                  mask_in_b,    // Mask B
    input wire logic                  mask_in_c,    // Mask C
    input wire logic                  cmp_raw,      // Raw result
    input wire cmb_pkg::cmb_route_t   route,        // Steering
    input wire logic                  cmp_out,      // Blanked
    input wire logic                  blank_active  // OR result
);
    // Write taken; a register may move up to two edges later
    logic wr_take;
    assign wr_take = hsel && hready && htrans[1] && hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd(logic [9:0] w);
        hsel && hready && htrans[1] && !hwrite && haddr[11:2] == w;
    endsequence
    property p_okay;
        hresp == 1'b0 && hreadyout == 1'b1;
    endproperty
    a_okay: assert property (p_okay) else $error("Bus answer wrong");
    property p_unmapped;
        s_rd(10'h4) |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read not zero");
    property p_bit14;
        s_rd(10'h0) |=> hrdata[31:16] == 16'h0 && hrdata[14] == 1'b0;
    endproperty
    a_bit14: assert property (p_bit14)
        else $error("Gating read bad bits");
    property p_src_w;
        s_rd(10'h1) |=> hrdata[31:4] == 28'h0;
    endproperty
    a_src_w: assert property (p_src_w)
        else $error("Source read bad bits");
    property p_cmp4_w;
        s_rd(10'h2) |=> hrdata[31:5] == 27'h0 && hrdata[3:2] == 2'h0;
    endproperty
    a_cmp4_w: assert property (p_cmp4_w)
        else $error("Control read bad bits");
    property p_pass;
        !blank_active && $past(hresetn) |-> cmp_out == $past(cmp_raw);
    endproperty
    a_pass: assert property (p_pass)
        else $error("Unblanked output wrong");
    property p_hold;
        blank_active && $past(blank_active) && !$past(wr_take)
            && !$past(wr_take, 2) |-> $stable(cmp_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Blanked output moved");
    property p_reset;
        $rose(hresetn) |-> route == '0 && !cmp_out && !blank_active;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Outputs not cleared");
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
// ========================================================
// Testbench for the blanking block
module tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic [9:0]  pat = 10'h0;
    logic        mb = 1'b0;
    logic        mc = 1'b0;
    logic        craw = 1'b0;
    logic        cmp_out;
    logic        blank_active;
    int          error_cnt = 0;
    int          num_checks = 0;
    logic [31:0] wm [3] = '{32'hbfff, 32'h000f, 32'h0013};
    logic [3:0]  cd [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                             4'hc, 4'hd, 4'he, 4'hf};
    cmb_pkg::cmb_sources_t src;
    cmb_pkg::cmb_route_t   route;
    initial forever #10 hclk = ~hclk;
    cmb_src_model u_src (.hclk(hclk), .hresetn(hresetn), .pat(pat),
        .src(src));
    cmb_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mask_a_src(src),
        .mask_in_b(mb), .mask_in_c(mc), .cmp_raw(craw), .route(route),
        .cmp_out(cmp_out), .blank_active(blank_active));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // One single transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [15:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 16'h0);
        chk(rd, e);
    endtask
    // Source model and output stage each add a cycle
    task automatic settle();
        repeat (3) @(posedge hclk);
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rdchk(12'(4 * i), 32'h0);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, 12'(4 * i), 16'hffff);
            rdchk(12'(4 * i), wm[i]);
        end
        for (int r = 0; r < 8; r++) begin
            xfer(1'b1, 12'h8, {11'h0, r[0], 2'h0, r[2:1]});
            settle();
            chk(32'(route), 32'(r));
        end
        // Each source code, level high then low on its line only
        xfer(1'b1, 12'h0, 16'h0200);
        for (int i = 0; i < 10; i++) begin
            xfer(1'b1, 12'h4, {12'h0, cd[i]});
            pat <= 10'h200 >> i;
            settle();
            rdchk(12'hc, 32'h6);
            pat <= ~(10'h200 >> i);
            settle();
            rdchk(12'hc, 32'h0);
        end
        // Reserved codes: mask A stays low even with all lines high
        pat <= 10'h3ff;
        for (int i = 6; i < 12; i++) begin
            xfer(1'b1, 12'h4, 16'(i));
            settle();
            chk(blank_active, 1'b0);
        end
        xfer(1'b1, 12'h4, 16'h0);
        for (int k = 8; k < 14; k++)
            for (int v = 0; v < 2; v++) begin
                xfer(1'b1, 12'h0, 16'(1 << k));
                pat <= {10{v[0]}};
                mb <= v[0];
                mc <= v[0];
                settle();
                chk(blank_active, k[0] ? v[0] : !v[0]);
            end
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, 12'h0, {c[2], 6'h0, 1'b1, 8'h0});
            pat <= {10{c[1]}};
            craw <= c[0];
            settle();
            chk(cmp_out, c[1] ? c[0] : c[2]);
        end
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, 12'h0, c[1] ? 16'h0082 : 16'h0042);
            pat <= {10{c[0]}};
            settle();
            chk(blank_active, c[1] ^ c[0]);
        end
        print_verdict();
    end
endmodule
bind cmb_top cmb_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mask_a_src(mask_a_src),
    .mask_in_b(mask_in_b), .mask_in_c(mask_in_c), .cmp_raw(cmp_raw),
    .route(route), .cmp_out(cmp_out), .blank_active(blank_active));
